// ---- shared/pcs_cfg.svh ----
// Constants for the per-channel select and master mode register bank.
// Assumes inclusion by bare name from files that use these macros.
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ==========================================================================
// Register offsets on the parallel port
`define PCS_ADDR_MASTER 8'h00
`define PCS_ADDR_PTR 8'h28
`define PCS_ADDR_MAP1 8'h29
`define PCS_ADDR_MAP2 8'h2A
`define PCS_ADDR_MAP3 8'h2B
`define PCS_ADDR_MAP4 8'h2C

// ==========================================================================
// Master mode fields
`define PCS_MM_SOFT 0
`define PCS_MM_STD 1
`define PCS_MM_TEST_LSB 2
`define PCS_MM_TEST_MSB 3
`define PCS_TEST_NORMAL 2'h0
`define PCS_TEST_TRISTATE 2'h1
`define PCS_TEST_LOW 2'h2
`define PCS_TEST_HIGH 2'h3

// ==========================================================================
// Pointer bits, one per feature
`define PCS_FEAT_TX_TESTER 0
`define PCS_FEAT_TX_FRACT 1
`define PCS_FEAT_PAYLOAD_ERR 2
`define PCS_FEAT_TX_HW_SIG 3
`define PCS_FEAT_RX_TESTER 4
`define PCS_FEAT_RX_FRACT 5
`define PCS_FEAT_RX_SIG_REINS 6
`define PCS_FEAT_RX_SIG_ONES 7

// ==========================================================================
// Sizes
`define PCS_NUM_FEAT 8
`define PCS_NUM_BYTES 4
`define PCS_BYTE_IDX_W 2
`define PCS_FEAT_IDX_W 3
`define PCS_LAST_FEAT 3'h7
`define PCS_RESET_VAL 8'h00

// ==========================================================================
// Timing: line unit recovery, clock rate
`define PCS_LIU_RECOVER_MS 40
`define PCS_CLK_HZ 40000000
`define PCS_MS_PER_S 1000
`define PCS_LU_CNT_W 21

`endif

// ---- shared/pcs_pkg.sv ----
// Types for the per-channel select and master mode register bank.
// Assumes pcs_cfg.svh is on the include path.
`default_nettype none
`include "pcs_cfg.svh"

package pcs_pkg;

  // ========================================================================
  // Reset sequencer states
  typedef enum logic [1:0] {
    PCS_RS_IDLE = 2'b00,
    PCS_RS_HOLD = 2'b01,
    PCS_RS_SWEEP = 2'b10
  } pcs_rst_state_t;

  // ========================================================================
  // Channel map store state
  typedef struct packed {
    logic [`PCS_NUM_FEAT-1:0][`PCS_NUM_BYTES-1:0][7:0] map;
    logic [`PCS_FEAT_IDX_W-1:0] idx;
    logic busy;
  } pcs_store_state_t;

  // ========================================================================
  // Register bank state
  typedef struct packed {
    pcs_rst_state_t rs;
    logic [7:0] ptr;
    logic std_e1;
    logic [1:0] test;
    logic soft_bit;
    logic traffic_hold;
    logic [2:0] hw_sync;
    logic hw_level;
    logic lu_prev;
    logic lu_pulse;
    logic lu_busy;
    logic [`PCS_LU_CNT_W-1:0] lu_cnt;
    logic [7:0] rdata;
    logic rd_drive;
  } pcs_bank_state_t;

endpackage : pcs_pkg
`default_nettype wire

// ---- hw/pcs_map_store.sv ----
// Channel map store: one 32-channel map per feature, with clear sweep.
// Assumes an asynchronous active-low reset already released cleanly.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_map_store (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic [`PCS_BYTE_IDX_W-1:0] byte_i,
  input wire logic [7:0] data_i,
  input wire logic [`PCS_NUM_FEAT-1:0] sel_i,
  // Results
  output logic [`PCS_NUM_FEAT-1:0][31:0] map_o,
  output logic busy_o
);

  pcs_pkg::pcs_store_state_t st;
  pcs_pkg::pcs_store_state_t nx;

  // ========================================================================
  // Next state: clear sweep first, then selected-feature writes
  always_comb
  begin
    nx = st;
    if (clr_i)
    begin
      nx.busy = 1'b1;
      nx.idx = '0;
    end
    else if (st.busy)
    begin
      nx.map[st.idx] = '0;
      nx.idx = st.idx + 3'h1;
      if (st.idx == `PCS_LAST_FEAT)
      begin
        nx.busy = 1'b0;
      end
    end
    else if (wr_i)
    begin
      for (int f = 0; f < `PCS_NUM_FEAT; f++)
      begin
        if (sel_i[f])
        begin
          nx.map[f][byte_i] = data_i;
        end
      end
    end
  end

  // State register, power-up clears all maps
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= nx;
    end
  end

  // Map outputs, feature index equals pointer bit
  for (genvar f = 0; f < `PCS_NUM_FEAT; f++)
  begin : g_map
    assign map_o[f] = st.map[f];
  end
  assign busy_o = st.busy;

  // ========================================================================
  // Checks
  property p_write_selected;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_i && !clr_i && !st.busy && sel_i[`PCS_FEAT_RX_TESTER]
      |=> st.map[`PCS_FEAT_RX_TESTER][$past(byte_i)] == $past(data_i);
  endproperty
  a_write_selected: assert property (p_write_selected)
    else $error("selected feature map not written");

  property p_write_unselected;
    @(posedge clk_i) disable iff (!rst_n_i)
    !clr_i && !st.busy && !sel_i[`PCS_FEAT_TX_TESTER]
      |=> $stable(st.map[`PCS_FEAT_TX_TESTER]);
  endproperty
  a_write_unselected: assert property (p_write_unselected)
    else $error("unselected feature map changed");

  property p_sweep_clears;
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(st.busy) |-> st.map == '0;
  endproperty
  a_sweep_clears: assert property (p_sweep_clears)
    else $error("maps not zero after clear sweep");

endmodule : pcs_map_store
`default_nettype wire

// ---- hw/pcs_regbank.sv ----
// Per-channel select and master mode register bank for one transceiver.
// Assumes host strobes are one-cycle pulses synchronous to CLK_SYS_I.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

// What this block does
// - Pointer bits choose features; later map writes go to all chosen.
// - Four map bytes; channel n is bit (n-1) mod 8 of byte (n-1)/8.
// - Pointer bits 0-3: tx tester, tx fractional, payload error, tx signaling.
// - Pointer bits 4-7: rx tester, rx fractional, reinsertion, all-ones.
// - Any reset clears pointer, maps, standard and test bits to zero and sets traffic hold.
// - Power-up reset clears writeable registers with no host action.
// - Chip reset any time from hardware pin or software bit.
// - Soft bit 0-to-1 clears registers; bit self-clears when done.
// - Master bit 1 picks framer standard: 0 for T1, 1 for E1.
// - Test bits: normal, tristate all, force low, force high.
// - Line unit reset on 0-to-1 bit; about 40 ms to recover.
// - After reset traffic stays disrupted until host reprograms device.
module pcs_regbank #(
  parameter int unsigned LIU_RECOVER_CYC =
    `PCS_LIU_RECOVER_MS * (`PCS_CLK_HZ / `PCS_MS_PER_S)
) (
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_N_I,
  input wire logic HW_RESET_PIN_I,
  // Parallel port
  input wire logic [7:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] DATA_I,
  output logic [7:0] DATA_O,
  output logic DATA_OE_N_O,
  // Line unit reset
  input wire logic LINE_UNIT_RESET_BIT_I,
  output logic LINE_UNIT_RST_O,
  output logic LINE_UNIT_READY_O,
  // Feature channel maps, index equals pointer bit
  output logic [`PCS_NUM_FEAT-1:0][31:0] CHAN_MAP_O,
  // Mode and status
  output logic LINE_STANDARD_E1_O,
  output logic PIN_TRISTATE_O,
  output logic PIN_FORCE_LO_O,
  output logic PIN_FORCE_HI_O,
  output logic TRAFFIC_HOLD_O,
  output logic RESET_BUSY_O
);

  // ========================================================================
  // Reset release
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge CLK_SYS_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      rst_pipe <= 2'h0;
    end
    else
    begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ========================================================================
  // Map byte decode: hit flag and byte index
  function automatic logic [2:0] map_slot(input logic [7:0] a);
    case (a)
      `PCS_ADDR_MAP1: map_slot = 3'h4;
      `PCS_ADDR_MAP2: map_slot = 3'h5;
      `PCS_ADDR_MAP3: map_slot = 3'h6;
      `PCS_ADDR_MAP4: map_slot = 3'h7;
      default: map_slot = 3'h0;
    endcase
  endfunction : map_slot

  pcs_pkg::pcs_bank_state_t st;
  pcs_pkg::pcs_bank_state_t nx;
  logic [2:0] wr_slot;
  logic [2:0] rd_slot;
  logic wr_master;
  logic start_soft;
  logic store_clr;
  logic store_busy;
  logic store_wr;
  logic [`PCS_NUM_FEAT-1:0][31:0] maps;
  logic [`PCS_FEAT_IDX_W-1:0] rd_feat;
  logic [7:0] rd_mux;
  logic lu_rise;

  // Decode of host strobes
  assign wr_slot = map_slot(ADDR_I);
  assign rd_slot = map_slot(ADDR_I);
  assign wr_master = WR_I && (ADDR_I == `PCS_ADDR_MASTER);
  assign start_soft = wr_master && DATA_I[`PCS_MM_SOFT] && !st.soft_bit
    && (st.rs == pcs_pkg::PCS_RS_IDLE);
  assign store_wr = WR_I && wr_slot[2] && (st.rs == pcs_pkg::PCS_RS_IDLE);
  assign store_clr = start_soft || (st.rs == pcs_pkg::PCS_RS_HOLD);
  assign lu_rise = LINE_UNIT_RESET_BIT_I && !st.lu_prev;

  // Read mux: lowest selected feature's map byte
  always_comb
  begin
    rd_feat = '0;
    for (int f = `PCS_NUM_FEAT - 1; f >= 0; f--)
    begin
      if (st.ptr[f])
      begin
        rd_feat = f[`PCS_FEAT_IDX_W-1:0];
      end
    end
    rd_mux = `PCS_RESET_VAL;
    if (ADDR_I == `PCS_ADDR_MASTER)
    begin
      rd_mux = {4'h0, st.test, st.std_e1, st.soft_bit};
    end
    else if (ADDR_I == `PCS_ADDR_PTR)
    begin
      rd_mux = st.ptr;
    end
    else if (rd_slot[2])
    begin
      rd_mux = maps[rd_feat][rd_slot[1:0]*8 +: 8];
    end
  end

  // ========================================================================
  // Next state
  always_comb
  begin
    nx = st;
    // Pin synchroniser, change taken once second and third agree
    nx.hw_sync = {st.hw_sync[1:0], HW_RESET_PIN_I};
    if (st.hw_sync[1] == st.hw_sync[2])
    begin
      nx.hw_level = st.hw_sync[2];
    end
    case (st.rs)
      pcs_pkg::PCS_RS_IDLE:
      begin
        if (st.hw_level)
        begin
          nx.rs = pcs_pkg::PCS_RS_HOLD;
        end
        else if (start_soft)
        begin
          nx.rs = pcs_pkg::PCS_RS_SWEEP;
          nx.soft_bit = 1'b1;
        end
        else if (wr_master)
        begin
          nx.std_e1 = DATA_I[`PCS_MM_STD];
          nx.test = DATA_I[`PCS_MM_TEST_MSB:`PCS_MM_TEST_LSB];
          nx.traffic_hold = 1'b0;
        end
        else if (WR_I && (ADDR_I == `PCS_ADDR_PTR))
        begin
          nx.ptr = DATA_I;
        end
      end
      pcs_pkg::PCS_RS_HOLD:
      begin
        if (!st.hw_level)
        begin
          nx.rs = pcs_pkg::PCS_RS_SWEEP;
        end
      end
      pcs_pkg::PCS_RS_SWEEP:
      begin
        if (st.hw_level)
        begin
          nx.rs = pcs_pkg::PCS_RS_HOLD;
          nx.soft_bit = 1'b0;
        end
        else if (!store_busy)
        begin
          nx.rs = pcs_pkg::PCS_RS_IDLE;
          nx.soft_bit = 1'b0;
        end
      end
      default:
      begin
        nx.rs = pcs_pkg::PCS_RS_IDLE;
      end
    endcase
    // Any reset in progress keeps registers clear
    if (nx.rs != pcs_pkg::PCS_RS_IDLE)
    begin
      nx.ptr = `PCS_RESET_VAL;
      nx.std_e1 = 1'b0;
      nx.test = `PCS_TEST_NORMAL;
      nx.traffic_hold = 1'b1;
    end
    // Line unit reset and recovery count
    nx.lu_prev = LINE_UNIT_RESET_BIT_I;
    nx.lu_pulse = lu_rise;
    if (lu_rise)
    begin
      nx.lu_busy = 1'b1;
      nx.lu_cnt = `PCS_LU_CNT_W'(LIU_RECOVER_CYC - 1);
    end
    else if (st.lu_busy)
    begin
      if (st.lu_cnt == '0)
      begin
        nx.lu_busy = 1'b0;
      end
      else
      begin
        nx.lu_cnt = st.lu_cnt - 1'b1;
      end
    end
    // Read data, driven the cycle after the strobe
    nx.rd_drive = RD_I;
    if (RD_I)
    begin
      nx.rdata = rd_mux;
    end
  end

  // State register, power-up value
  always_ff @(posedge CLK_SYS_I or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '{rs: pcs_pkg::PCS_RS_IDLE, traffic_hold: 1'b1,
        default: '0};
    end
    else
    begin
      st <= nx;
    end
  end

  // Channel map store
  pcs_map_store u_store (
    .clk_i(CLK_SYS_I),
    .rst_n_i(rst_n),
    .clr_i(store_clr),
    .wr_i(store_wr),
    .byte_i(wr_slot[1:0]),
    .data_i(DATA_I),
    .sel_i(st.ptr),
    .map_o(maps),
    .busy_o(store_busy)
  );

  // ========================================================================
  // Outputs
  assign CHAN_MAP_O = maps;
  assign DATA_O = st.rdata;
  assign DATA_OE_N_O = !(st.rd_drive && (st.test != `PCS_TEST_TRISTATE));
  assign LINE_UNIT_RST_O = st.lu_pulse;
  assign LINE_UNIT_READY_O = !st.lu_busy;
  assign LINE_STANDARD_E1_O = st.std_e1;
  assign PIN_TRISTATE_O = (st.test == `PCS_TEST_TRISTATE);
  assign PIN_FORCE_LO_O = (st.test == `PCS_TEST_LOW);
  assign PIN_FORCE_HI_O = (st.test == `PCS_TEST_HIGH);
  assign TRAFFIC_HOLD_O = st.traffic_hold;
  assign RESET_BUSY_O = (st.rs != pcs_pkg::PCS_RS_IDLE);

  // ========================================================================
  // Checks
  property p_soft_start;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    start_soft && !st.hw_level |=> st.soft_bit && RESET_BUSY_O;
  endproperty
  a_soft_start: assert property (p_soft_start)
    else $error("soft reset did not start");

  property p_soft_done;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    $rose(st.soft_bit) |-> ##[1:12] !st.soft_bit;
  endproperty
  a_soft_done: assert property (p_soft_done)
    else $error("soft reset bit did not self-clear");

  property p_reset_clears;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    RESET_BUSY_O |-> st.ptr == '0 && !st.std_e1 && st.test == '0;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("registers not clear during reset");

  property p_std_write;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    wr_master && !start_soft && !st.hw_level && !RESET_BUSY_O
      |=> LINE_STANDARD_E1_O == $past(DATA_I[`PCS_MM_STD]);
  endproperty
  a_std_write: assert property (p_std_write)
    else $error("standard select not taken from write");

  property p_tristate;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    st.test == `PCS_TEST_TRISTATE |-> DATA_OE_N_O && PIN_TRISTATE_O
      && !PIN_FORCE_LO_O && !PIN_FORCE_HI_O;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("tristate test mode leaks a drive");

  property p_hold_kept;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    TRAFFIC_HOLD_O && !wr_master |=> TRAFFIC_HOLD_O;
  endproperty
  a_hold_kept: assert property (p_hold_kept)
    else $error("traffic hold dropped without reprogramming");

  property p_lu_busy;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    lu_rise |=> LINE_UNIT_RST_O && !LINE_UNIT_READY_O ##1 !LINE_UNIT_RST_O;
  endproperty
  a_lu_busy: assert property (p_lu_busy)
    else $error("line unit reset not started");

  property p_pin_reset;
    @(posedge CLK_SYS_I) disable iff (!rst_n)
    st.hw_level && !RESET_BUSY_O |=> st.rs == pcs_pkg::PCS_RS_HOLD;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("hardware reset pin ignored");

endmodule : pcs_regbank
`default_nettype wire

// ---- verif/pcs_host_model.sv ----
// Host processor model driving the parallel port of the register bank.
// Assumes one strobe per cycle, changed just after rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module pcs_host_model (
  // Clock
  input wire logic clk_i,
  // Port towards the bank
  output logic [7:0] addr_o,
  output logic wr_o,
  output logic rd_o,
  output logic [7:0] data_o,
  input wire logic [7:0] data_i,
  input wire logic data_oe_n_i
);
  // ========================================================================
  // Idle bus at time zero
  initial
  begin
    addr_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    data_o = 8'h00;
  end

  // One write; data then left showing its inverse
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wr_o <= 1'b1;
    data_o <= (a == 8'h00) ? (d & 8'h0F) : d;
    @(posedge clk_i);
    wr_o <= 1'b0;
    data_o <= ~data_o;
  endtask : put

  // One read; data and enable taken just after the edge that takes it
  task automatic get(input logic [7:0] a, output logic [7:0] d,
                     output logic oe_n);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    #1;
    d = data_i;
    oe_n = data_oe_n_i;
  endtask : get
endmodule : pcs_host_model
`default_nettype wire

// ---- verif/test_per_channel_select_master_mode.sv ----
// Self-checking bench for the register bank, with a host model.
// Assumes the bank and its include file are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"
module test_per_channel_select_master_mode;
  localparam int LIU = 20;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hw = 1'b0;
  logic lub = 1'b0;
  logic [7:0] addr, wdat, rdat;
  logic wr, rd, oe_n, lu_rst, lu_rdy, e1, tri_s, f_lo, f_hi, hold, busy;
  logic [`PCS_NUM_FEAT-1:0][31:0] cmap;
  logic [7:0] mm [8][4];
  logic [7:0] ptr_m, p, d, v;
  logic [1:0] b;
  logic o;
  int mismatches = 0;
  int n_tests = 0;

  // ========================================================================
  // Clock
  initial
  begin
    forever #12.5 clk = ~clk;
  end

  // Design and host
  pcs_regbank #(.LIU_RECOVER_CYC(LIU)) u_pcs_regbank (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .HW_RESET_PIN_I(hw),
    .ADDR_I(addr), .WR_I(wr), .RD_I(rd), .DATA_I(wdat),
    .DATA_O(rdat), .DATA_OE_N_O(oe_n),
    .LINE_UNIT_RESET_BIT_I(lub), .LINE_UNIT_RST_O(lu_rst),
    .LINE_UNIT_READY_O(lu_rdy), .CHAN_MAP_O(cmap),
    .LINE_STANDARD_E1_O(e1), .PIN_TRISTATE_O(tri_s),
    .PIN_FORCE_LO_O(f_lo), .PIN_FORCE_HI_O(f_hi),
    .TRAFFIC_HOLD_O(hold), .RESET_BUSY_O(busy));
  pcs_host_model u_pcs_host_model (
    .clk_i(clk), .addr_o(addr), .wr_o(wr), .rd_o(rd), .data_o(wdat),
    .data_i(rdat), .data_oe_n_i(oe_n));

  // ========================================================================
  // Comparison and verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("mismatches %0d of %0d compares", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // Reference model helpers
  function automatic int pick(input logic [7:0] q);
    pick = 0;
    for (int f = 7; f >= 0; f--)
      if (q[f])
        pick = f;
  endfunction : pick

  task automatic clr_model();
    ptr_m = 8'h00;
    foreach (mm[f, k])
      mm[f][k] = 8'h00;
  endtask : clr_model

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_pcs_host_model.get(a, v, o);
    check({o, v}, {1'b0, exp});
  endtask : rd_chk

  task automatic wr_ptr(input logic [7:0] q);
    u_pcs_host_model.put(8'h28, q);
    ptr_m = q;
  endtask : wr_ptr

  task automatic wr_map(input logic [1:0] k, input logic [7:0] q);
    u_pcs_host_model.put(8'h29 + {6'h00, k}, q);
    for (int f = 0; f < 8; f++)
      if (ptr_m[f])
        mm[f][k] = q;
  endtask : wr_map

  task automatic maps_chk();
    settle();
    for (int f = 0; f < 8; f++)
      check(cmap[f], {mm[f][3], mm[f][2], mm[f][1], mm[f][0]});
  endtask : maps_chk

  task automatic wait_idle();
    for (int k = 0; k < 60 && busy !== 1'b0; k++)
      settle();
    check(busy, 1'b0);
    clr_model();
  endtask : wait_idle

  // ========================================================================
  // Watchdog
  initial
  begin
    #(25 * 20000);
    mismatches++;
    close_out();
  end

  // Main sequence
  initial
  begin
    void'($urandom(32'h7519c151));
    clr_model();
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Power-up state
    check(hold, 1'b1);
    maps_chk();
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h28, 8'h00);
    // Elastic stores live outside this bank; host has none to reset
    // Standard first, then every test mode
    u_pcs_host_model.put(8'h00, 8'h02);
    settle();
    check({e1, hold}, 2'b10);
    for (int t = 0; t < 4; t++)
    begin
      u_pcs_host_model.put(8'h00, {4'h0, t[1:0], 2'b00});
      settle();
      check({tri_s, f_lo, f_hi, e1}, {t == 1, t == 2, t == 3, 1'b0});
      u_pcs_host_model.get(8'h00, v, o);
      check(o, t == 1);
      if (t != 1)
        check(v, {4'h0, t[1:0], 2'b00});
    end
    u_pcs_host_model.put(8'h00, 8'h00);
    // Worked example: tx and rx tester on 9-12, 20, 21
    wr_ptr(8'h11);
    wr_map(2'd0, 8'h00);
    wr_map(2'd1, 8'h0F);
    wr_map(2'd2, 8'h18);
    wr_map(2'd3, 8'h00);
    maps_chk();
    check(cmap[0], 32'h00180F00);
    rd_chk(8'h2A, 8'h0F);
    // Each pointer bit alone, none, then random sets
    for (int i = 0; i < 24; i++)
    begin
      p = (i < 8) ? (8'h01 << i) : ((i == 8) ? 8'h00 : 8'($urandom));
      b = 2'($urandom);
      d = 8'($urandom);
      wr_ptr(p);
      wr_map(b, d);
      maps_chk();
      rd_chk(8'h28, p);
      rd_chk(8'h29 + {6'h00, b}, mm[pick(p)][b]);
    end
    // Unmapped place
    u_pcs_host_model.put(8'h40, 8'hA5);
    rd_chk(8'h40, 8'h00);
    maps_chk();
    // Soft reset, with a write dropped while it runs
    wr_ptr(8'hFF);
    wr_map(2'd3, 8'hC3);
    u_pcs_host_model.put(8'h00, 8'h01);
    settle();
    check({busy, hold}, 2'b11);
    u_pcs_host_model.put(8'h28, 8'h7E);
    wait_idle();
    maps_chk();
    rd_chk(8'h28, 8'h00);
    rd_chk(8'h00, 8'h00);
    check(hold, 1'b1);
    // Hardware reset pin
    wr_ptr(8'h81);
    wr_map(2'd2, 8'h5A);
    @(posedge clk);
    hw <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check({busy, hold}, 2'b11);
    @(posedge clk);
    hw <= 1'b0;
    wait_idle();
    maps_chk();
    rd_chk(8'h28, 8'h00);
    // Line unit reset and recovery
    @(posedge clk);
    lub <= 1'b1;
    settle();
    check({lu_rst, lu_rdy}, 2'b10);
    settle();
    check(lu_rst, 1'b0);
    repeat (LIU - 4) @(posedge clk);
    #1;
    check(lu_rdy, 1'b0);
    for (int k = 0; k < 8 && lu_rdy !== 1'b1; k++)
      settle();
    check(lu_rdy, 1'b1);
    lub <= 1'b0;
    close_out();
  end
endmodule : test_per_channel_select_master_mode
`default_nettype wire
